// ---- bench/ucs_strap_model.sv ----
`timescale 1ns/1ps
// ************************************************************
// Strap resistors on the three configuration pins
// ************************************************************
module ucs_strap_model
   import ucs_pkg::*;
(
   input wire logic [3:0] STEP_A_I,
   input wire logic [3:0] STEP_B_I,
   input wire logic [3:0] STEP_C_I,
   input wire logic LOADED_I,
   output logic [RES_W-1:0] OHMS_A_O,
   output logic [RES_W-1:0] OHMS_B_O,
   output logic [RES_W-1:0] OHMS_C_O
);
   // Nominal resistor per step; top step stands for an open pin
   function automatic logic [RES_W-1:0] step_ohms(input logic [3:0] s);
      logic [RES_W-1:0] tbl [16];
      tbl = '{17'd0, 17'd590, 17'd931, 17'd1300, 17'd1740, 17'd2260, 17'd2940, 17'd3740,
              17'd4750, 17'd6040, 17'd7870, 17'd10500, 17'd14700, 17'd22600, 17'd43200, 17'd80000};
      return tbl[s];
   endfunction

   // After the load the pins are two-wire lines again, so they no longer hold the strap value
   always_comb begin
      OHMS_A_O = LOADED_I ? ~step_ohms(STEP_A_I) : step_ohms(STEP_A_I);
      OHMS_B_O = LOADED_I ? ~step_ohms(STEP_B_I) : step_ohms(STEP_B_I);
      OHMS_C_O = LOADED_I ? ~step_ohms(STEP_C_I) : step_ohms(STEP_C_I);
   end
endmodule

// ---- bench/usb_port_config_and_switch_mode_tb.sv ----
`timescale 1ns/1ps
module usb_port_config_and_switch_mode_tb;
   import ucs_pkg::*;
   logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, en = 0, sup = 1, prof = 0, emu = 0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [3:0] sa = '0, sb = '0, sc = '0;
   logic [RES_W-1:0] oa, ob, oc;
   logic [31:0] rd [2];
   logic [1:0] err;
   logic [31:0] prd [2];
   logic prdy [2], perr [2], pas [2], emo [2], inv [2], spr [2], syn [2], done [2];
   logic [4:0] gn [2];
   logic [2:0] lim [2];
   logic [6:0] ta [2];
   int n_fail = 0, compares = 0;

   initial begin
      forever #20 clk = ~clk;
   end

   ucs_strap_model i_ucs_strap_model(.STEP_A_I(sa), .STEP_B_I(sb), .STEP_C_I(sc),
      .LOADED_I(done[0] & done[1]), .OHMS_A_O(oa), .OHMS_B_O(ob), .OHMS_C_O(oc));

   // Instance 0 is the bus-configurable variant, instance 1 the strap-only one
   for (genvar g = 0; g < 2; g++) begin : g_var
      ucs_port_config #(.BUS_VARIANT(g == 0)) i_ucs_port_config(.SYS_CLK_I(clk), .RST_I(rst),
         .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
         .PRDATA_O(prd[g]), .PREADY_O(prdy[g]), .PSLVERR_O(perr[g]), .HIGH_VOLTAGE_ENABLE_I(en),
         .SUPPLY_OK_I(sup), .PROFILE_SEL_I(prof), .EMULATION_ACTIVE_I(emu), .STRAP_PIN_A_OHMS_I(oa),
         .STRAP_PIN_B_OHMS_I(ob), .STRAP_PIN_C_OHMS_I(oc), .PASS_SWITCH_O(pas[g]),
         .EMULATION_SWITCH_O(emo[g]), .MODE_INVALID_O(inv[g]), .SPREAD_EN_O(spr[g]),
         .SYNC_DIR_IN_O(syn[g]), .GAIN_O(gn[g]), .DC_LIMIT_SEL_O(lim[g]), .TARGET_ADDR_O(ta[g]),
         .LOAD_DONE_O(done[g]));
   end

   // ************************************************************
   // Reporting
   // ************************************************************
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         $display("unexpected %s: expected %h seen %h", what, exp, got);
         n_fail++;
      end
   endtask

   task automatic end_of_test();
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ************************************************************
   // APB master and expectations
   // ************************************************************
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (prdy[0] !== 1'b1 && n < 50);
      rd[0] = prd[0];
      rd[1] = prd[1];
      err = {perr[1], perr[0]};
      psel <= 1'b0;
      penable <= 1'b0;
      chk("apb wait", 0, n >= 50);
      chk("strap variant ready", 1, prdy[1]);
   endtask

   // {spread, sync_in, target address, gain, limit} after a load
   function automatic logic [16:0] exp_load(input bit bus, input logic [3:0] a, b, c);
      logic [3:0] s;
      s = bus ? a : (a & 4'hC);
      return {~s[3], ~s[2], TARGET_ADDR_UPPER, s[1:0], bus ? 5'h00 : {c[2], b},
              bus ? 3'h4 : ((c[1:0] == 2'h0) ? 3'h0 : 3'h4)};
   endfunction

   // {invalid, emulation, pass}
   function automatic logic [2:0] exp_mode(input bit bus, input logic e, s, p, m, input logic [1:0] cd);
      if (!e) return 3'b000;
      if (!s) return 3'b100;
      if (p || (bus && cd == 2'h1)) return {1'b0, m, ~m};
      return 3'b001;
   endfunction

   task automatic load(input logic [3:0] a, b, c);
      int n;
      logic [16:0] e;
      @(posedge clk);
      en <= 1'b0;
      sup <= 1'b1;
      prof <= 1'b0;
      sa <= a;
      sb <= b;
      sc <= c;
      repeat (5) @(posedge clk);
      en <= 1'b1;
      n = 0;
      while (!(done[0] === 1'b1 && done[1] === 1'b1) && n < 100) begin
         @(posedge clk);
         n++;
      end
      repeat (3) @(posedge clk);
      chk("load wait", 0, n >= 100);
      for (int g = 0; g < 2; g++) begin
         chk("loaded", exp_load(g == 0, a, b, c), {spr[g], syn[g], ta[g], gn[g], lim[g]});
         chk("pass at startup", 3'b001, {inv[g], emo[g], pas[g]});
      end
      apb(1'b0, ADDR_STEPS, 32'h0000_0000);
      chk("steps", {20'h0_0000, c, b, a}, rd[0]);
      apb(1'b0, ADDR_SETUP0, 32'h0000_0000);
      for (int g = 0; g < 2; g++) begin
         e = exp_load(g == 0, a, b, c);
         chk("setup0", {16'h0000, SWITCHING_FREQ_KHZ, 2'b00, e[15], e[16]}, rd[g]);
      end
      $display("load test done a=%0d b=%0d c=%0d", a, b, c);
   endtask

   // ************************************************************
   // Tests
   // ************************************************************
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      end_of_test();
   end

   initial begin
      logic [1:0] cd;
      void'($urandom(10043));
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk("reset outputs", {3'h4, 7'h30, 5'h00, 1'b0}, {lim[0], ta[0], gn[0], done[0]});
      apb(1'b1, ADDR_SETUP1, 32'h0000_0011);
      chk("early write refused", 2'b11, err);
      $display("reset test done");
      load(4'h0, 4'h0, 4'h0);
      load(4'hF, 4'hF, 4'hF);
      load(4'h4, 4'h8, 4'h4);
      load(4'hC, 4'h5, 4'h8);
      load(4'h9, 4'h3, 4'h1);
      for (int i = 0; i < 8; i++) begin
         load(4'($urandom), 4'($urandom), 4'($urandom));
      end
      apb(1'b1, ADDR_SETUP1, 32'h0000_001F);
      chk("gain write", 0, err);
      @(posedge clk);
      chk("gain out", 5'h1F, gn[0]);
      chk("strap gain out", 5'h1F, gn[1]);
      apb(1'b0, ADDR_SETUP1, 32'h0000_0000);
      chk("gain read", 32'h0000_001F, rd[0]);
      for (int v = 0; v < 6; v++) begin
         apb(1'b1, ADDR_SETUP2, 32'(v));
         chk("limit refusal", {2{v > 4}}, err);
         apb(1'b0, ADDR_SETUP2, 32'h0000_0000);
         chk("limit read", (v > 4) ? 32'h0000_0004 : 32'(v), rd[0]);
      end
      apb(1'b0, 8'h18, 32'h0000_0000);
      chk("unmapped", 2'b11, err);
      apb(1'b1, ADDR_STATUS, 32'h0000_0FFF);
      chk("status write", 2'b11, err);
      $display("register test done");
      for (int i = 0; i < 48; i++) begin
         cd = (i < 32) ? 2'(i >> 3) : 2'($urandom);
         apb(1'b1, ADDR_CTRL, {30'h0, cd});
         @(posedge clk);
         sup <= (i < 32) ? i[0] : 1'($urandom);
         prof <= (i < 32) ? i[1] : 1'($urandom);
         emu <= (i < 32) ? i[2] : 1'($urandom);
         repeat (6) @(posedge clk);
         for (int g = 0; g < 2; g++) begin
            chk("mode", exp_mode(g == 0, 1'b1, sup, prof, emu, cd), {inv[g], emo[g], pas[g]});
         end
         apb(1'b0, ADDR_STATUS, 32'h0000_0000);
         chk("status", {1'b1, exp_mode(1'b1, 1'b1, sup, prof, emu, cd)}, rd[0][11:8]);
      end
      @(posedge clk);
      en <= 1'b0;
      repeat (6) @(posedge clk);
      for (int g = 0; g < 2; g++) begin
         chk("disabled", 4'h0, {inv[g], emo[g], pas[g], done[g]});
      end
      $display("mode test done");
      end_of_test();
   end
endmodule

// ---- rtl/ucs_pkg.sv ----
package ucs_pkg;
   // ************************************************************
   // APB register map (byte addresses)
   // ************************************************************
   localparam logic [7:0] ADDR_SETUP0 = 8'h00;
   localparam logic [7:0] ADDR_SETUP1 = 8'h04;
   localparam logic [7:0] ADDR_SETUP2 = 8'h08;
   localparam logic [7:0] ADDR_CTRL = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_STEPS = 8'h14;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int SETUP0_SPREAD_BIT = 0;
   localparam int SETUP0_SYNC_IN_BIT = 1;
   localparam int SETUP0_FREQ_LSB = 4;
   localparam int STATUS_ADDR_LSB = 0;
   localparam int STATUS_PASS_BIT = 8;
   localparam int STATUS_EMU_BIT = 9;
   localparam int STATUS_INVALID_BIT = 10;
   localparam int STATUS_DONE_BIT = 11;
   localparam int STEPS_B_LSB = 4;
   localparam int STEPS_C_LSB = 8;

   // ************************************************************
   // Values and reset values
   // ************************************************************
   localparam logic [11:0] SWITCHING_FREQ_KHZ = 12'h0898;
   localparam logic [4:0] TARGET_ADDR_UPPER = 5'h0C;
   localparam logic [2:0] LIM_CODE_0P55 = 3'h0;
   localparam logic [2:0] LIM_CODE_1P62 = 3'h4;
   localparam logic [2:0] LIM_CODE_MAX = 3'h4;
   localparam logic [2:0] RST_DC_LIMIT = 3'h4;
   localparam logic [4:0] RST_GAIN = 5'h00;
   localparam logic [1:0] RST_CHARGE_DETECT = 2'h0;
   localparam logic [3:0] STRAP_A_ACCEPT_MASK = 4'hC;

   // ************************************************************
   // Strap quantizer thresholds in ohms, midway between steps except the top one (57350)
   // ************************************************************
   localparam int RES_W = 17;
   localparam int NUM_THRESH = 15;
   localparam logic [RES_W-1:0] STRAP_THRESH [NUM_THRESH] = '{
      17'd295, 17'd760, 17'd1115, 17'd1520, 17'd2000, 17'd2600, 17'd3340, 17'd4245,
      17'd5395, 17'd6955, 17'd9185, 17'd12600, 17'd18650, 17'd32900, 17'd57350};

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_FREQ_HZ = 25000000;
   localparam int SETTLE_TIME_NS = 1000;
   localparam int SETTLE_CYC = (SETTLE_TIME_NS * (CLK_FREQ_HZ / 1000000) + 999) / 1000;

   typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_LOAD, ST_RUN} ucs_state_t;
endpackage

// ---- rtl/ucs_port_config.sv ----
`timescale 1ns/1ps
//Contract
// - Bus variant picks DC limit from a 3-bit field, five values.
// - Strap variant offers only a subset of limits, from strap C step.
// - Bus variant holds a 5-bit droop gain field.
// - Strap variant: gain low four bits from strap B, msb from strap C.
// - Bus variant: enable low opens switches; cd/profile choose pass or CDP.
// - Enable high with supply low is an invalid mode; the code flags it only once the sequencer has reached run.
// - Strap variant: profile low pass-through, high CDP with emulation steering.
// - Profile low at startup gives pass-through, except in the bus variant with cd kept at 1 from an earlier run.
// - Role swap needs no register write.
// - Strap values preload registers once the settle time has passed after the enable rising edge.
// - After startup software may overwrite preloaded registers; the code refuses writes to the status and steps words.
// - Bus variant: strap A gives spread enable and sync direction.
// - Strap A decode: spread on 0-7, sync in 0-3/8-11, address low step mod 4.
// - Strap variant uses the two-wire pins as straps B and C.
// - Strap variant: strap A sets frequency, sync direction and spread.
// - Strap variant accepts steps 0,4,8,12, all at 2200 kHz.
// - Strap variant: strap C sets limit and gain msb.
// - Strap B step is gain low bits; strap C step 0 gives msb 0, 0.55 A.
// - Spread enable sits in setup 0, preloaded from strap A.
// - Target address is a fixed upper part plus strap A low bits.
module ucs_port_config
   import ucs_pkg::*;
#(
   parameter bit BUS_VARIANT = 1'b1
) (
   input wire logic SYS_CLK_I,
   input wire logic RST_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic HIGH_VOLTAGE_ENABLE_I,
   input wire logic SUPPLY_OK_I,
   input wire logic PROFILE_SEL_I,
   input wire logic EMULATION_ACTIVE_I,
   input wire logic [RES_W-1:0] STRAP_PIN_A_OHMS_I,
   input wire logic [RES_W-1:0] STRAP_PIN_B_OHMS_I,
   input wire logic [RES_W-1:0] STRAP_PIN_C_OHMS_I,
   output logic PASS_SWITCH_O,
   output logic EMULATION_SWITCH_O,
   output logic MODE_INVALID_O,
   output logic SPREAD_EN_O,
   output logic SYNC_DIR_IN_O,
   output logic [4:0] GAIN_O,
   output logic [2:0] DC_LIMIT_SEL_O,
   output logic [6:0] TARGET_ADDR_O,
   output logic LOAD_DONE_O
);
   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   logic [3:0] pin_s1_reg;
   logic [3:0] pin_s2_reg;
   logic hv_s3_reg;
   logic [RES_W-1:0] res_s1_reg [3];
   logic [RES_W-1:0] res_s2_reg [3];
   logic hv_s2, sup_s2, prof_s2, emu_s2, hv_rise;

   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         pin_s1_reg <= 4'h0;
         pin_s2_reg <= 4'h0;
         hv_s3_reg <= 1'b0;
      end else begin
         pin_s1_reg <= {EMULATION_ACTIVE_I, PROFILE_SEL_I, SUPPLY_OK_I, HIGH_VOLTAGE_ENABLE_I};
         pin_s2_reg <= pin_s1_reg;
         hv_s3_reg <= pin_s2_reg[0];
      end
   end

   // Resistance codes only matter at the load instant, long after settle
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         res_s1_reg <= '{default: '0};
         res_s2_reg <= '{default: '0};
      end else begin
         res_s1_reg <= '{STRAP_PIN_A_OHMS_I, STRAP_PIN_B_OHMS_I, STRAP_PIN_C_OHMS_I};
         res_s2_reg <= res_s1_reg;
      end
   end

   assign hv_s2 = pin_s2_reg[0];
   assign sup_s2 = pin_s2_reg[1];
   assign prof_s2 = pin_s2_reg[2];
   assign emu_s2 = pin_s2_reg[3];
   assign hv_rise = hv_s2 & ~hv_s3_reg;

   // ************************************************************
   // Strap quantizer
   // ************************************************************
   logic [NUM_THRESH-1:0] above [3];
   logic [3:0] step_a, step_b, step_c;

   for (genvar p = 0; p < 3; p++) begin : g_pin
      for (genvar t = 0; t < NUM_THRESH; t++) begin : g_th
         assign above[p][t] = res_s2_reg[p] >= STRAP_THRESH[t];
      end
   end

   always_comb begin
      step_a = 4'h0;
      step_b = 4'h0;
      step_c = 4'h0;
      for (int t = 0; t < NUM_THRESH; t++) begin
         step_a = step_a + 4'(above[0][t]);
         step_b = step_b + 4'(above[1][t]);
         step_c = step_c + 4'(above[2][t]);
      end
      if (!BUS_VARIANT) begin
         step_a = step_a & STRAP_A_ACCEPT_MASK;
      end
   end

   // ************************************************************
   // Startup sequencer
   // ************************************************************
   ucs_state_t state_reg, state_next;
   logic [7:0] settle_cnt_reg;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE: begin
            if (hv_rise) begin
               state_next = ST_SETTLE;
            end
         end
         ST_SETTLE: begin
            if (settle_cnt_reg == 8'(SETTLE_CYC - 1)) begin
               state_next = ST_LOAD;
            end
         end
         ST_LOAD: state_next = ST_RUN;
         ST_RUN: state_next = ST_RUN;
      endcase
      if (!hv_s2) begin
         state_next = ST_IDLE;
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         state_reg <= ST_IDLE;
         settle_cnt_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         settle_cnt_reg <= (state_reg == ST_SETTLE) ? settle_cnt_reg + 8'h01 : 8'h00;
      end
   end

   // ************************************************************
   // APB slave, one wait state
   // ************************************************************
   logic apb_access, wr_fire, addr_ok, wr_bad;
   logic [31:0] rd_data;
   logic spread_reg, sync_in_reg;
   logic [4:0] gain_reg;
   logic [2:0] limit_reg;
   logic [1:0] cd_reg, addr_lo_reg;
   logic [11:0] steps_reg;
   logic pass_reg, emu_reg, invalid_reg, done_reg;

   assign apb_access = PSEL_I & PENABLE_I & ~PREADY_O;
   // Writes land on the completing edge, as the master samples pready
   assign wr_fire = PSEL_I & PENABLE_I & PWRITE_I & PREADY_O & ~PSLVERR_O;

   always_comb begin
      addr_ok = 1'b1;
      rd_data = 32'h0000_0000;
      unique case (PADDR_I)
         ADDR_SETUP0: begin
            rd_data[SETUP0_SPREAD_BIT] = spread_reg;
            rd_data[SETUP0_SYNC_IN_BIT] = sync_in_reg;
            rd_data[SETUP0_FREQ_LSB +: 12] = SWITCHING_FREQ_KHZ;
         end
         ADDR_SETUP1: rd_data[4:0] = gain_reg;
         ADDR_SETUP2: rd_data[2:0] = limit_reg;
         ADDR_CTRL: rd_data[1:0] = cd_reg;
         ADDR_STATUS: begin
            rd_data[STATUS_ADDR_LSB +: 7] = {TARGET_ADDR_UPPER, addr_lo_reg};
            rd_data[STATUS_PASS_BIT] = pass_reg;
            rd_data[STATUS_EMU_BIT] = emu_reg;
            rd_data[STATUS_INVALID_BIT] = invalid_reg;
            rd_data[STATUS_DONE_BIT] = done_reg;
         end
         ADDR_STEPS: rd_data[11:0] = steps_reg;
         default: addr_ok = 1'b0;
      endcase
      // Only setup and control words are writable, and only once running
      wr_bad = (state_reg != ST_RUN) || (PADDR_I == ADDR_STATUS) || (PADDR_I == ADDR_STEPS)
         || ((PADDR_I == ADDR_SETUP2) && (PWDATA_I[2:0] > LIM_CODE_MAX));
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         PREADY_O <= 1'b0;
         PSLVERR_O <= 1'b0;
         PRDATA_O <= 32'h0000_0000;
      end else begin
         PREADY_O <= apb_access;
         PSLVERR_O <= apb_access & (~addr_ok | (PWRITE_I & wr_bad));
         PRDATA_O <= (apb_access & ~PWRITE_I & addr_ok) ? rd_data : 32'h0000_0000;
      end
   end

   // ************************************************************
   // Configuration registers
   // ************************************************************
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         spread_reg <= 1'b0;
         sync_in_reg <= 1'b0;
      end else if (state_reg == ST_LOAD) begin
         spread_reg <= ~step_a[3];
         sync_in_reg <= ~step_a[2];
      end else if (wr_fire && PADDR_I == ADDR_SETUP0) begin
         spread_reg <= PWDATA_I[SETUP0_SPREAD_BIT];
         sync_in_reg <= PWDATA_I[SETUP0_SYNC_IN_BIT];
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         gain_reg <= RST_GAIN;
      end else if (state_reg == ST_LOAD && !BUS_VARIANT) begin
         gain_reg <= {step_c[2], step_b};
      end else if (wr_fire && PADDR_I == ADDR_SETUP1) begin
         gain_reg <= PWDATA_I[4:0];
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         limit_reg <= RST_DC_LIMIT;
      end else if (state_reg == ST_LOAD && !BUS_VARIANT) begin
         limit_reg <= (step_c[1:0] == 2'h0) ? LIM_CODE_0P55 : LIM_CODE_1P62;
      end else if (wr_fire && PADDR_I == ADDR_SETUP2) begin
         limit_reg <= PWDATA_I[2:0];
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         cd_reg <= RST_CHARGE_DETECT;
      end else if (wr_fire && PADDR_I == ADDR_CTRL && BUS_VARIANT) begin
         cd_reg <= PWDATA_I[1:0];
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         addr_lo_reg <= 2'h0;
         steps_reg <= 12'h000;
         done_reg <= 1'b0;
      end else if (state_reg == ST_LOAD) begin
         addr_lo_reg <= step_a[1:0];
         steps_reg <= {step_c, step_b, step_a};
         done_reg <= 1'b1;
      end else if (state_reg == ST_IDLE) begin
         done_reg <= 1'b0;
      end
   end

   // ************************************************************
   // Data switch mode, straight from pins so role swaps need no software
   // ************************************************************
   logic cdp_mode;

   always_comb begin
      if (BUS_VARIANT) begin
         cdp_mode = (cd_reg == 2'h1) | prof_s2;
      end else begin
         cdp_mode = prof_s2;
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         pass_reg <= 1'b0;
         emu_reg <= 1'b0;
         invalid_reg <= 1'b0;
      end else if (!hv_s2 || state_reg != ST_RUN) begin
         pass_reg <= 1'b0;
         emu_reg <= 1'b0;
         invalid_reg <= 1'b0;
      end else if (!sup_s2) begin
         pass_reg <= 1'b0;
         emu_reg <= 1'b0;
         invalid_reg <= 1'b1;
      end else if (cdp_mode) begin
         pass_reg <= ~emu_s2;
         emu_reg <= emu_s2;
         invalid_reg <= 1'b0;
      end else begin
         // Pass-through with no controller help keeps role swaps safe
         pass_reg <= 1'b1;
         emu_reg <= 1'b0;
         invalid_reg <= 1'b0;
      end
   end

   assign PASS_SWITCH_O = pass_reg;
   assign EMULATION_SWITCH_O = emu_reg;
   assign MODE_INVALID_O = invalid_reg;
   assign SPREAD_EN_O = spread_reg;
   assign SYNC_DIR_IN_O = sync_in_reg;
   assign GAIN_O = gain_reg;
   assign DC_LIMIT_SEL_O = limit_reg;
   assign TARGET_ADDR_O = {TARGET_ADDR_UPPER, addr_lo_reg};
   assign LOAD_DONE_O = done_reg;

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (RST_I);

   AST_LIMIT_RANGE: assert property (limit_reg <= LIM_CODE_MAX)
      else $error("DC limit code out of range");
   AST_STRAP_LIMIT: assert property ((!BUS_VARIANT && $past(state_reg) == ST_LOAD)
      |-> (limit_reg == (($past(step_c[1:0]) == 2'h0) ? LIM_CODE_0P55 : LIM_CODE_1P62)))
      else $error("Strap limit decode wrong");
   AST_GAIN_LOAD: assert property ((!BUS_VARIANT && state_reg == ST_LOAD)
      |=> gain_reg == {$past(step_c[2]), $past(step_b)})
      else $error("Strap gain load wrong");
   AST_OFF: assert property (!hv_s2 |=> !PASS_SWITCH_O && !EMULATION_SWITCH_O)
      else $error("Switches closed with enable low");
   AST_INVALID: assert property ((hv_s2 && !sup_s2 && state_reg == ST_RUN)
      |=> MODE_INVALID_O && !PASS_SWITCH_O)
      else $error("Missing supply not flagged invalid");
   AST_PASS_LOW_PROFILE: assert property ((state_reg == ST_RUN && hv_s2 && sup_s2 && !prof_s2
      && cd_reg == 2'h0) |=> PASS_SWITCH_O && !EMULATION_SWITCH_O)
      else $error("Not in pass-through with profile low");
   AST_CDP_STEER: assert property ((state_reg == ST_RUN && hv_s2 && sup_s2 && prof_s2)
      |=> EMULATION_SWITCH_O == $past(emu_s2) && PASS_SWITCH_O == !$past(emu_s2))
      else $error("CDP switch steering wrong");
   AST_LOAD_DONE: assert property ((state_reg == ST_LOAD && hv_s2)
      |=> LOAD_DONE_O && state_reg == ST_RUN)
      else $error("Load did not complete");
   AST_SPREAD_LOAD: assert property (state_reg == ST_LOAD
      |=> SPREAD_EN_O == !$past(step_a[3]) && SYNC_DIR_IN_O == !$past(step_a[2]))
      else $error("Strap A decode wrong");
   AST_ADDR_LOAD: assert property (state_reg == ST_LOAD
      |=> TARGET_ADDR_O == {TARGET_ADDR_UPPER, $past(step_a[1:0])})
      else $error("Target address wrong");
   AST_WRITE_BEFORE_RUN: assert property ((apb_access && PWRITE_I && state_reg != ST_RUN)
      |=> PREADY_O && PSLVERR_O)
      else $error("Early write not refused");
   AST_GAIN_WRITE: assert property ((wr_fire && PADDR_I == ADDR_SETUP1)
      |=> GAIN_O == $past(PWDATA_I[4:0]))
      else $error("Accepted gain write did not land");
   AST_READY_PULSE: assert property (PREADY_O
      |=> !PREADY_O)
      else $error("Ready held longer than one cycle");
   AST_IDLE_CLEARS_DONE: assert property (state_reg == ST_IDLE
      |=> !LOAD_DONE_O)
      else $error("Load done left set while idle");

   COV_LOAD: cover property (state_reg == ST_LOAD ##1 state_reg == ST_RUN);
   COV_CDP: cover property (EMULATION_SWITCH_O ##[1:20] PASS_SWITCH_O);
   COV_WRITE: cover property (wr_fire && PADDR_I == ADDR_SETUP1);
   COV_INVALID: cover property (MODE_INVALID_O);
endmodule
